// >>> src/pmm_pkg.sv
package pmm_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          PMM_ADDR_W      = 5;
    localparam int          PMM_DATA_W      = 16;
    localparam logic [4:0]  PMM_REG_ADDR    = 5'h17;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          PMM_B_MAC_AN    = 13;
    localparam int          PMM_B_MAC_MODE  = 12;
    localparam int          PMM_B_AMS_PREF  = 11;
    localparam int          PMM_F_MEDIA_HI  = 10;
    localparam int          PMM_F_MEDIA_LO  = 8;
    localparam int          PMM_F_OVR_HI    = 7;
    localparam int          PMM_F_OVR_LO    = 6;
    localparam int          PMM_B_FE_LOOP   = 3;
    localparam int          PMM_B_ALIGN_ERR = 1;

    // ----------------------------------------------------------------
    // Strap layout
    // ----------------------------------------------------------------
    localparam int          PMM_STRAP_W     = 4;
    localparam int          PMM_S_MAC_AN    = 3;
    localparam int          PMM_S_MEDIA_HI  = 2;
    localparam int          PMM_S_MEDIA_LO  = 0;

    // ----------------------------------------------------------------
    // Encodings and reset values
    // ----------------------------------------------------------------
    localparam logic [2:0]  PMM_MED_COPPER  = 3'h0;
    localparam logic [2:0]  PMM_MED_PASS    = 3'h1;
    localparam logic [2:0]  PMM_MED_1000X   = 3'h2;
    localparam logic [2:0]  PMM_MED_100FX   = 3'h3;
    localparam logic [2:0]  PMM_MED_RSVD    = 3'h4;
    localparam logic [2:0]  PMM_MED_AMS_PT  = 3'h5;
    localparam logic [2:0]  PMM_MED_AMS_1KX = 3'h6;
    localparam logic [2:0]  PMM_MED_AMS_FX  = 3'h7;

    typedef enum logic [1:0] {
        PMM_OVR_NORMAL = 2'b00,
        PMM_OVR_SERDES = 2'b01,
        PMM_OVR_COPPER = 2'b10,
        PMM_OVR_RSVD   = 2'b11
    } pmm_ovr_t;

    localparam logic        PMM_RST_MAC_MODE = 1'b0;
    localparam logic        PMM_RST_AMS_PREF = 1'b0;
    localparam logic [1:0]  PMM_RST_OVR      = 2'h0;
    localparam logic        PMM_RST_FE_LOOP  = 1'b0;
    localparam logic [15:0] PMM_RD_UNMAPPED  = 16'h0000;

endpackage

// >>> src/pmm_rc_flag.sv
`timescale 1ns/1ps
`default_nettype none

module pmm_rc_flag (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic srst,
    // Event and clear
    input  wire logic set_evt,
    input  wire logic clr_rd,
    // Flag
    output logic      flag
);

    // ----------------------------------------------------------------
    // Sticky flag, cleared by a read.
    // ----------------------------------------------------------------
    // An event in the clearing cycle is kept, so no error goes unseen.
    wire next_flag = set_evt | (flag & ~clr_rd);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            flag <= 1'b0;
        end else begin
            flag <= next_flag;
        end
    end

endmodule

`default_nettype wire

// >>> src/pmm_ctrl.sv
// Operation
// - Bit 13 enables MAC autonegotiation, strap default.
// - Bit 12 picks 1000BASE-X or SGMII, 0.
// - Bit 11 picks preferred sensed medium, 0.
// - Field 10:8 codes 000-011 single media.
// - Codes 101-111 sense copper or other; strapped.
// - Field 7:6 forces serdes, copper or automatic in codes 101-111.
// - Bit 1 flags alignment error, clears on read.
// - Bits 13:8 pend until software reset applies.
// - Reads of 13:8 show mode in force.
// - Bits 13:8 survive software reset always.
`timescale 1ns/1ps
`default_nettype none

module pmm_ctrl (
    // Clock and reset
    input  wire logic                         clk_sys,
    input  wire logic                         srst,
    // Configuration straps
    input  wire logic [pmm_pkg::PMM_STRAP_W-1:0] config_strap_pins,
    // Management register access
    input  wire logic [pmm_pkg::PMM_ADDR_W-1:0]  reg_addr,
    input  wire logic                         reg_wr_en,
    input  wire logic                         reg_rd_en,
    input  wire logic [pmm_pkg::PMM_DATA_W-1:0]  reg_wdata,
    output logic [pmm_pkg::PMM_DATA_W-1:0]       reg_rdata,
    output logic                              reg_rvalid,
    input  wire logic                         sw_reset,
    // Line side events
    input  wire logic                         sgmii_align_err,
    // Operating mode in force
    output logic                              mac_an_en,
    output logic                              mac_mode_1000x,
    output logic                              auto_media_select_pref_copper,
    output logic [2:0]                        media_mode,
    output logic [1:0]                        media_override,
    output logic                              far_end_loopback,
    // Media decode
    output logic                              copper_allowed,
    output logic                              serdes_allowed,
    output logic                              auto_media_select
);
    import pmm_pkg::*;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire       hit    = (reg_addr == PMM_REG_ADDR);
    wire       wr_hit = hit & reg_wr_en;
    wire       rd_hit = hit & reg_rd_en;

    logic       pend_mac_an;
    logic       pend_mac_mode;
    logic       pend_ams_pref;
    logic [2:0] pend_media;
    logic       align_flag;

    wire       strap_an    = config_strap_pins[PMM_S_MAC_AN];
    wire [2:0] strap_media = config_strap_pins[PMM_S_MEDIA_HI:PMM_S_MEDIA_LO];

    // ----------------------------------------------------------------
    // Pending copy of bits 13:8
    // ----------------------------------------------------------------
    // Only the power-on reset and register writes touch these; a software reset leaves them.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pend_mac_an   <= strap_an;
            pend_mac_mode <= PMM_RST_MAC_MODE;
            pend_ams_pref <= PMM_RST_AMS_PREF;
            pend_media    <= strap_media;
        end else if (wr_hit) begin
            pend_mac_an   <= reg_wdata[PMM_B_MAC_AN];
            pend_mac_mode <= reg_wdata[PMM_B_MAC_MODE];
            pend_ams_pref <= reg_wdata[PMM_B_AMS_PREF];
            pend_media    <= reg_wdata[PMM_F_MEDIA_HI:PMM_F_MEDIA_LO];
        end
    end

    // ----------------------------------------------------------------
    // Mode in force
    // ----------------------------------------------------------------
    // The software reset copies the pending value held before this cycle.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mac_an_en                     <= strap_an;
            mac_mode_1000x                <= PMM_RST_MAC_MODE;
            auto_media_select_pref_copper <= PMM_RST_AMS_PREF;
            media_mode                    <= strap_media;
        end else if (sw_reset) begin
            mac_an_en                     <= pend_mac_an;
            mac_mode_1000x                <= pend_mac_mode;
            auto_media_select_pref_copper <= pend_ams_pref;
            media_mode                    <= pend_media;
        end
    end

    // ----------------------------------------------------------------
    // Immediate controls
    // ----------------------------------------------------------------
    // These are not super-sticky, so a software reset returns them to default.
    always_ff @(posedge clk_sys) begin
        if (srst || sw_reset) begin
            media_override   <= PMM_RST_OVR;
            far_end_loopback <= PMM_RST_FE_LOOP;
        end else if (wr_hit) begin
            media_override   <= reg_wdata[PMM_F_OVR_HI:PMM_F_OVR_LO];
            far_end_loopback <= reg_wdata[PMM_B_FE_LOOP];
        end
    end

    // ----------------------------------------------------------------
    // Alignment error flag
    // ----------------------------------------------------------------
    pmm_rc_flag pmm_rc_flag_inst (
        .clk_sys (clk_sys),
        .srst    (srst),
        .set_evt (sgmii_align_err),
        .clr_rd  (rd_hit),
        .flag    (align_flag)
    );

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Bits 13:8 return the mode in force, never the pending copy.
    wire [15:0] rd_word = {2'b00, mac_an_en, mac_mode_1000x, auto_media_select_pref_copper,
                           media_mode, media_override, 2'b00, far_end_loopback, 1'b0,
                           align_flag, 1'b0};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata  <= PMM_RD_UNMAPPED;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= hit ? rd_word : PMM_RD_UNMAPPED;
            end
        end
    end

    // ----------------------------------------------------------------
    // Media decode
    // ----------------------------------------------------------------
    // The reserved mode code is treated as copper only, the safest fallback.
    wire copper_only = (media_mode == PMM_MED_COPPER) | (media_mode == PMM_MED_RSVD);
    wire sensing     = media_mode[2] & ~copper_only;
    wire ovr_serdes  = (media_override == PMM_OVR_SERDES);
    wire ovr_copper  = (media_override == PMM_OVR_COPPER);

    assign copper_allowed    = copper_only | (sensing & ~ovr_serdes);
    assign serdes_allowed    = ~copper_only & (~sensing | ~ovr_copper);
    assign auto_media_select = sensing & ~ovr_serdes & ~ovr_copper;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_strap_mac_an: assert property (@(posedge clk_sys) $fell(srst) |->
        mac_an_en == $past(config_strap_pins[PMM_S_MAC_AN]))
        else $error("MAC autonegotiation not loaded from strap");

    chk_reset_defaults: assert property (@(posedge clk_sys) $fell(srst) |->
        !mac_mode_1000x && !auto_media_select_pref_copper && media_override == PMM_RST_OVR)
        else $error("Mode defaults wrong after reset");

    chk_strap_media: assert property (@(posedge clk_sys) $fell(srst) |->
        media_mode == $past(config_strap_pins[PMM_S_MEDIA_HI:PMM_S_MEDIA_LO]))
        else $error("Media mode not loaded from strap");

    chk_pending_holds: assert property (@(posedge clk_sys) disable iff (srst)
        !sw_reset ##1 !sw_reset |-> $stable(media_mode) && $stable(mac_an_en) && $stable(mac_mode_1000x))
        else $error("Mode changed without software reset");

    chk_apply_pending: assert property (@(posedge clk_sys) disable iff (srst)
        wr_hit && !sw_reset ##1 sw_reset |=> media_mode == $past(reg_wdata[PMM_F_MEDIA_HI:PMM_F_MEDIA_LO], 2)
        && auto_media_select_pref_copper == $past(reg_wdata[PMM_B_AMS_PREF], 2))
        else $error("Pending mode not applied by software reset");

    chk_read_in_force: assert property (@(posedge clk_sys) disable iff (srst)
        rd_hit |=> reg_rvalid && reg_rdata[PMM_F_MEDIA_HI:PMM_F_MEDIA_LO] == $past(media_mode)
        && reg_rdata[PMM_B_MAC_AN] == $past(mac_an_en))
        else $error("Read of mode field not the mode in force");

    chk_sticky_keep: assert property (@(posedge clk_sys) disable iff (srst)
        sw_reset && !wr_hit |=> $stable(pend_media) && $stable(pend_mac_an))
        else $error("Pending mode lost by software reset");

    chk_align_read: assert property (@(posedge clk_sys) disable iff (srst)
        rd_hit && align_flag && !sgmii_align_err |=> !align_flag)
        else $error("Alignment flag not cleared by read");

    chk_align_set: assert property (@(posedge clk_sys) disable iff (srst)
        sgmii_align_err ##1 rd_hit |=> reg_rdata[PMM_B_ALIGN_ERR])
        else $error("Alignment error not reported");

    chk_loopback_wr: assert property (@(posedge clk_sys) disable iff (srst)
        wr_hit && !sw_reset |=> far_end_loopback == $past(reg_wdata[PMM_B_FE_LOOP]))
        else $error("Loopback bit not written");

    chk_force_copper: assert property (@(posedge clk_sys) disable iff (srst)
        media_override == PMM_OVR_COPPER && media_mode[2] |-> copper_allowed && !serdes_allowed)
        else $error("Copper force not honoured");

    chk_single_media: assert property (@(posedge clk_sys) disable iff (srst)
        !media_mode[2] |-> !auto_media_select && (copper_allowed != serdes_allowed))
        else $error("Single media mode decode wrong");

    chk_flag_set_wins: assert property (@(posedge clk_sys) disable iff (srst)
        sgmii_align_err |=> align_flag)
        else $error("Alignment error lost");

    chk_override_clear: assert property (@(posedge clk_sys) disable iff (srst)
        sw_reset |=> media_override == PMM_RST_OVR && far_end_loopback == PMM_RST_FE_LOOP)
        else $error("Override or loopback kept through software reset");

    chk_force_serdes: assert property (@(posedge clk_sys) disable iff (srst)
        media_override == PMM_OVR_SERDES && sensing |-> serdes_allowed && !copper_allowed)
        else $error("Serdes force not honoured");

    chk_auto_sense: assert property (@(posedge clk_sys) disable iff (srst)
        sensing && media_override != PMM_OVR_SERDES && media_override != PMM_OVR_COPPER |->
        auto_media_select && copper_allowed && serdes_allowed)
        else $error("Sensing mode decode wrong");

endmodule

`default_nettype wire

// >>> sim/pmm_mac_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Line partner that raises alignment error events on request.
// ----------------------------------------------------------------
module pmm_mac_model (
    // Clock
    input  wire logic clk_sys,
    // Line side event
    output logic      sgmii_align_err
);
    initial sgmii_align_err = 1'b0;

    // Edges fall between clock edges, so the block never samples a changing level.
    task automatic align_burst(input int n);
        repeat (n) begin
            @(negedge clk_sys);
            sgmii_align_err = 1'b1;
        end
        @(negedge clk_sys);
        sgmii_align_err = 1'b0;
    endtask
endmodule

`default_nettype wire

// >>> sim/phy_media_mode_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module phy_media_mode_control_tb;
    import pmm_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        clk_sys   = 1'b0;
    logic        srst      = 1'b1;
    logic [3:0]  straps    = 4'he;
    logic [4:0]  reg_addr  = 5'h00;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        sw_reset  = 1'b0;
    logic        align_err;
    logic [15:0] reg_rdata;
    logic        reg_rvalid, mac_an_en, mac_mode_1000x, pref_copper, far_end_loopback;
    logic [2:0]  media_mode;
    logic [1:0]  media_override;
    logic        copper_allowed, serdes_allowed, auto_media_select;
    int          n_errors    = 0;
    int          comparisons = 0;

    always #4 clk_sys = ~clk_sys;

    pmm_ctrl pmm_ctrl_inst (
        .clk_sys(clk_sys), .srst(srst), .config_strap_pins(straps),
        .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sw_reset(sw_reset), .sgmii_align_err(align_err), .mac_an_en(mac_an_en),
        .mac_mode_1000x(mac_mode_1000x), .auto_media_select_pref_copper(pref_copper),
        .media_mode(media_mode), .media_override(media_override),
        .far_end_loopback(far_end_loopback), .copper_allowed(copper_allowed),
        .serdes_allowed(serdes_allowed), .auto_media_select(auto_media_select)
    );

    pmm_mac_model pmm_mac_model_inst (.clk_sys(clk_sys), .sgmii_align_err(align_err));

    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
    endtask

    // reg_rvalid stands for one cycle only, so the answer is looked at in that cycle.
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(negedge clk_sys);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk_sys);
        reg_rd_en = 1'b0;
        chk({15'h0, reg_rvalid}, 16'h0001);
        chk(reg_rdata, exp);
    endtask

    task automatic swr();
        @(negedge clk_sys);
        sw_reset = 1'b1;
        @(negedge clk_sys);
        sw_reset = 1'b0;
    endtask

    task automatic wr_swr(input logic [15:0] d);
        @(negedge clk_sys);
        reg_addr = PMM_REG_ADDR;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk_sys);
        reg_wr_en = 1'b0;
        sw_reset = 1'b1;
        @(negedge clk_sys);
        sw_reset = 1'b0;
    endtask

    task automatic results();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        results();
    end

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [15:0] d;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        rd(PMM_REG_ADDR, 16'h2600);
        chk({13'h0, media_mode}, 16'h0006);
        chk({15'h0, mac_an_en}, 16'h0001);
        wr(5'h16, 16'hffff);
        rd(5'h16, 16'h0000);
        rd(PMM_REG_ADDR, 16'h2600);
        wr(PMM_REG_ADDR, 16'h1b88);
        rd(PMM_REG_ADDR, 16'h2688);
        chk({14'h0, media_override}, 16'h0002);
        chk({15'h0, far_end_loopback}, 16'h0001);
        straps = 4'h0;
        swr();
        rd(PMM_REG_ADDR, 16'h1b00);
        chk({15'h0, mac_an_en}, 16'h0000);
        chk({15'h0, mac_mode_1000x}, 16'h0001);
        chk({15'h0, pref_copper}, 16'h0001);
        chk({15'h0, far_end_loopback}, 16'h0000);
        swr();
        rd(PMM_REG_ADDR, 16'h1b00);
        for (int c = 0; c < 8; c++) begin
            if (c != 4) begin
                d = 16'(c) << 8;
                wr_swr(d);
                rd(PMM_REG_ADDR, d);
                chk({13'h0, media_mode}, 16'(c));
                chk({15'h0, auto_media_select}, {15'h0, c > 4});
                chk({15'h0, copper_allowed}, {15'h0, c == 0 || c > 4});
                chk({15'h0, serdes_allowed}, {15'h0, c != 0});
            end
        end
        for (int v = 1; v < 3; v++) begin
            wr(PMM_REG_ADDR, 16'h0700 | (16'(v) << 6));
            chk({15'h0, copper_allowed}, {15'h0, v == 2});
            chk({15'h0, serdes_allowed}, {15'h0, v == 1});
        end
        pmm_mac_model_inst.align_burst(1);
        rd(PMM_REG_ADDR, 16'h0782);
        rd(PMM_REG_ADDR, 16'h0780);
        fork
            pmm_mac_model_inst.align_burst(1);
            begin
                @(negedge clk_sys);
                rd(PMM_REG_ADDR, 16'h0782);
            end
        join
        fork
            pmm_mac_model_inst.align_burst(1);
            rd(PMM_REG_ADDR, 16'h0780);
        join
        rd(PMM_REG_ADDR, 16'h0782);
        @(negedge clk_sys);
        straps = 4'h5;
        srst = 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        srst = 1'b0;
        rd(PMM_REG_ADDR, 16'h0500);
        chk({15'h0, mac_an_en}, 16'h0000);
        swr();
        rd(PMM_REG_ADDR, 16'h0500);
        chk({15'h0, auto_media_select}, 16'h0001);
        results();
    end
endmodule

`default_nettype wire
